// *** rtl/prox_port_regs.vh ***
// Purpose: Offsets, field positions, reset values and timing counts of the proximity sensor host port.
// Assumes: System clock of 50 MHz.
// Notes:   Definitions only; included by prox_host_port.v and prox_cycle_seq.v.
`ifndef PROX_PORT_REGS_VH
`define PROX_PORT_REGS_VH

// Register offsets selected by the 5-bit target field of the command byte.
`define OFS_STATE_ENABLE   5'h00
`define OFS_CONV_TIME      5'h02
`define OFS_WAIT_DUR       5'h03
`define OFS_LOW_THR_LO     5'h08
`define OFS_LOW_THR_HI     5'h09
`define OFS_HIGH_THR_LO    5'h0a
`define OFS_HIGH_THR_HI    5'h0b
`define OFS_RANGE_FILTER   5'h0c
`define OFS_GENERAL_SETUP  5'h0d
`define OFS_PULSE_COUNT    5'h0e
`define OFS_DRIVE_GAIN     5'h0f
`define OFS_SIGNATURE      5'h12
`define OFS_STATE_FLAGS    5'h13
`define OFS_RESULT_LO      5'h18
`define OFS_RESULT_HI      5'h19
`define OFS_CROSSTALK      5'h1e

// Reset values.
`define RST_ZERO           8'h00
`define RST_CONV_TIME      8'hff
`define RST_WAIT_DUR       8'hff

// Command byte fields.
`define CMD_SELECT_BIT     7
`define CMD_TYPE_HI        6
`define CMD_TYPE_LO        5
`define TYPE_REPEAT        2'h0
`define TYPE_AUTO_INC      2'h1
`define TYPE_SPECIAL       2'h3
`define SF_FORCE_INT       5'h04
`define SF_CLEAR_INT       5'h05

// Enable, setup and flag bit positions.
`define EN_POWER_BIT       0
`define EN_PROX_BIT        2
`define EN_WAIT_BIT        3
`define EN_INT_OUT_BIT     5
`define SETUP_STRETCH_BIT  1
`define FLAG_VALID_BIT     1
`define FLAG_INT_BIT       5
`define FLAG_SAT_BIT       6

// Timing: figures in ns and derived clock counts.
`define CLK_PERIOD_NS      20
`define LED_ON_NS          7300
`define LED_OFF_NS         8700
`define TIME_UNIT_NS       2730000
`define LED_ON_CYC         ((`LED_ON_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LED_OFF_CYC        ((`LED_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIME_UNIT_CYC      (`TIME_UNIT_NS / `CLK_PERIOD_NS)
`define WAIT_STRETCH_MUL   12

`endif

// *** rtl/prox_cycle_seq.v ***
// Purpose: Measurement cycle sequencer with LED pulse timing.
// Assumes: All inputs come from logic on sys_clk.
// Notes:   Dropping run returns the sequencer to idle at once.
`timescale 1ns/1ps
`default_nettype none
`include "prox_port_regs.vh"
module prox_cycle_seq #(
   parameter UNIT_CYC = `TIME_UNIT_CYC
) (
   input  wire       sys_clk,
   input  wire       arst_n,
   input  wire       run,
   input  wire       wait_en,
   input  wire       wait_stretch,
   input  wire [7:0] led_pulse_count,
   input  wire [7:0] prox_conv_time,
   input  wire [7:0] wait_duration,
   output reg        led_on,
   output reg  [2:0] seq_state,
   output reg        cycle_done
);
   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_INIT   = 3'h1;
   localparam [2:0] ST_ACCUM  = 3'h2;
   localparam [2:0] ST_SETTLE = 3'h3;
   localparam [2:0] ST_CONV   = 3'h4;
   localparam [2:0] ST_WAIT   = 3'h5;
   localparam integer UNIT_LAST = UNIT_CYC - 1;
   localparam integer ON_LAST   = `LED_ON_CYC - 1;
   localparam integer OFF_LAST  = `LED_OFF_CYC - 1;

   reg  [17:0] cyc_q;
   reg  [7:0]  pulses_q;
   reg  [11:0] units_q;
   wire        unit_end = (cyc_q == UNIT_LAST[17:0]);
   wire [11:0] wait_base = 12'h100 - {4'h0, wait_duration};
   wire [11:0] wait_units = wait_stretch ? ((wait_base << 3) + (wait_base << 2)) : wait_base;

   // Steps init, accumulation, settling, conversion and optional wait, then repeats.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         seq_state  <= ST_IDLE;
         cyc_q      <= 18'h0;
         pulses_q   <= 8'h0;
         units_q    <= 12'h0;
         led_on     <= 1'b0;
         cycle_done <= 1'b0;
      end else begin
         cycle_done <= 1'b0;
         if (!run) begin
            seq_state <= ST_IDLE;
            led_on    <= 1'b0;
            cyc_q     <= 18'h0;
         end else begin
            case (seq_state)
               ST_IDLE: begin
                  seq_state <= ST_INIT;
                  cyc_q     <= 18'h0;
               end
               ST_INIT: begin
                  cyc_q <= unit_end ? 18'h0 : cyc_q + 18'h1; // RQ13
                  if (unit_end) begin
                     seq_state <= ST_ACCUM; // RQ18
                     pulses_q  <= 8'h0;
                     led_on    <= |led_pulse_count; // RQ1
                  end
               end
               ST_ACCUM: begin
                  if (led_on) begin
                     if (cyc_q == ON_LAST[17:0]) begin
                        cyc_q  <= 18'h0;
                        led_on <= 1'b0; // RQ1
                     end else begin
                        cyc_q <= cyc_q + 18'h1;
                     end
                  end else if (pulses_q == led_pulse_count) begin
                     seq_state <= ST_SETTLE; // RQ1
                     cyc_q     <= 18'h0;
                  end else if (cyc_q == OFF_LAST[17:0]) begin
                     cyc_q    <= 18'h0;
                     pulses_q <= pulses_q + 8'h1; // RQ2
                     led_on   <= ((pulses_q + 8'h1) != led_pulse_count); // RQ2
                  end else begin
                     cyc_q <= cyc_q + 18'h1;
                  end
               end
               ST_SETTLE: begin
                  cyc_q <= unit_end ? 18'h0 : cyc_q + 18'h1; // RQ13
                  if (unit_end) begin
                     seq_state <= ST_CONV;
                     units_q   <= 12'h100 - {4'h0, prox_conv_time}; // RQ14
                  end
               end
               ST_CONV: begin
                  cyc_q <= unit_end ? 18'h0 : cyc_q + 18'h1;
                  if (unit_end) begin
                     units_q <= units_q - 12'h1;
                     if (units_q == 12'h1) begin
                        cycle_done <= 1'b1;
                        seq_state  <= wait_en ? ST_WAIT : ST_INIT; // RQ3
                        units_q    <= wait_units; // RQ3
                     end
                  end
               end
               ST_WAIT: begin
                  cyc_q <= unit_end ? 18'h0 : cyc_q + 18'h1;
                  if (unit_end) begin
                     units_q <= units_q - 12'h1;
                     if (units_q == 12'h1) begin
                        seq_state <= ST_INIT; // RQ18
                     end
                  end
               end
               default: begin
                  seq_state <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** rtl/prox_host_port.v ***
// Purpose: Two-wire serial target port, register bank and cycle control of a proximity sensor.
// Assumes: scl_in and sda_in come from pins; result and event inputs come from logic on sys_clk.
// Notes:   SDA is open drain: sda_out is always low and sda_oe pulls the line.
// Summary of operation
// RQ1 - Each LED pulse stays on 7.3 us; pulse number equals the programmed count.
// RQ2 - After each on interval the LED stays off 8.7 us, 16 us period.
// RQ3 - Wait lasts (256 - wait_duration) units of 2.73 ms, twelvefold if stretched, else skipped.
// RQ4 - Target port answers one 7-bit bus address, never 10-bit addressing.
// RQ5 - Port works at both standard-mode and fast-mode bus rates.
// RQ6 - In a write the first byte is a command, later bytes are register data.
// RQ7 - Combined transfer: command write, repeated start, then reads of selected register.
// RQ8 - A read without command returns data from the last stored register address.
// RQ9 - First byte with clear MSB is data, written at the last stored address.
// RQ10 - Command byte is either a control action or a 5-bit register address.
// RQ11 - Control actions clear pending interrupts with no data byte needed.
// RQ12 - Host writes a command byte before accessing registers to select the target.
// RQ13 - Initialisation and settling each last a fixed 2.73 ms.
// RQ14 - Conversion lasts 1 to 256 units of 2.73 ms; all ones gives one.
// RQ15 - Type 00 repeats the register, 01 auto-increments, 11 is a special function.
// RQ16 - Special code 00101 clears interrupt and saturation; 00100 forces an interrupt.
// RQ17 - Unimplemented addresses read zero; writes to them or read-only registers are ignored.
// RQ18 - Sequencer runs init, accumulation, settling, conversion, optional wait, then repeats.
`timescale 1ns/1ps
`default_nettype none
`include "prox_port_regs.vh"
module prox_host_port #(
   parameter [6:0] BUS_ADDR  = 7'h2a,  // Arbitrary value.
   parameter [7:0] SIGNATURE = 8'h5a,  // Arbitrary value.
   parameter       UNIT_CYC  = `TIME_UNIT_CYC
) (
   input  wire        sys_clk,
   input  wire        arst_n,
   input  wire        scl_in,
   input  wire        sda_in,
   output wire        sda_out,
   output reg         sda_oe,
   input  wire [15:0] prox_result,
   input  wire        prox_irq_event,
   input  wire        prox_sat_event,
   output wire        led_on,
   output wire [2:0]  seq_state,
   output reg         prox_int
);
   localparam [1:0] PS_IDLE = 2'h0;
   localparam [1:0] PS_ADDR = 2'h1;
   localparam [1:0] PS_WR   = 2'h2;
   localparam [1:0] PS_RD   = 2'h3;

   // Writable registers, then the result and status flags.
   reg [7:0] state_enable_q;
   reg [7:0] conv_time_q;
   reg [7:0] wait_dur_q;
   reg [7:0] low_thr_lo_q;
   reg [7:0] low_thr_hi_q;
   reg [7:0] high_thr_lo_q;
   reg [7:0] high_thr_hi_q;
   reg [7:0] range_filter_q;
   reg [7:0] general_setup_q;
   reg [7:0] pulse_count_q;
   reg [7:0] drive_gain_q;
   reg [7:0] crosstalk_q;
   reg [15:0] result_q;
   reg        valid_q;
   reg        int_q;
   reg        sat_q;

   // Serial port state.
   reg        scl_s1_q;
   reg        scl_s2_q;
   reg        scl_d_q;
   reg        sda_s1_q;
   reg        sda_s2_q;
   reg        sda_d_q;
   reg [1:0]  port_state_q;
   reg [3:0]  bit_q;
   reg [7:0]  shift_q;
   reg        ack_phase_q;
   reg        first_q;
   reg [4:0]  ptr_q;
   reg [1:0]  type_q;
   reg [7:0]  rd_data;
   reg        wr_stb;
   reg [4:0]  wr_addr;
   reg [7:0]  wr_data;
   reg        clr_stb;
   reg        force_stb;
   wire       cycle_done;
   wire [7:0] state_flags;

   wire scl_rise = scl_s2_q & ~scl_d_q; // RQ5
   wire scl_fall = ~scl_s2_q & scl_d_q;
   wire start_c  = scl_s2_q & scl_d_q & sda_d_q & ~sda_s2_q;
   wire stop_c   = scl_s2_q & scl_d_q & ~sda_d_q & sda_s2_q;
   wire run      = state_enable_q[`EN_POWER_BIT] & state_enable_q[`EN_PROX_BIT];

   assign sda_out = 1'b0;
   assign state_flags = {1'b0, sat_q, int_q, 3'h0, valid_q, 1'b0};

   // Advances the register pointer after a byte when auto-increment is selected.
   function [4:0] next_ptr;
      input [4:0] ptr;
      input [1:0] typ;
      begin
         next_ptr = (typ == `TYPE_AUTO_INC) ? ptr + 5'h1 : ptr;
      end
   endfunction

   // Two-flop synchronisers on the pins, plus a delayed copy for edge detection.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_d_q  <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_d_q  <= 1'b1;
      end else begin
         scl_s1_q <= scl_in;
         scl_s2_q <= scl_s1_q;
         scl_d_q  <= scl_s2_q;
         sda_s1_q <= sda_in;
         sda_s2_q <= sda_s1_q;
         sda_d_q  <= sda_s2_q;
      end
   end

   // Read multiplexer over the register map.
   always @* begin
      case (ptr_q)
         `OFS_STATE_ENABLE:  rd_data = state_enable_q;
         `OFS_CONV_TIME:     rd_data = conv_time_q;
         `OFS_WAIT_DUR:      rd_data = wait_dur_q;
         `OFS_LOW_THR_LO:    rd_data = low_thr_lo_q;
         `OFS_LOW_THR_HI:    rd_data = low_thr_hi_q;
         `OFS_HIGH_THR_LO:   rd_data = high_thr_lo_q;
         `OFS_HIGH_THR_HI:   rd_data = high_thr_hi_q;
         `OFS_RANGE_FILTER:  rd_data = range_filter_q;
         `OFS_GENERAL_SETUP: rd_data = general_setup_q;
         `OFS_PULSE_COUNT:   rd_data = pulse_count_q;
         `OFS_DRIVE_GAIN:    rd_data = drive_gain_q;
         `OFS_SIGNATURE:     rd_data = SIGNATURE;
         `OFS_STATE_FLAGS:   rd_data = state_flags;
         `OFS_RESULT_LO:     rd_data = result_q[7:0];
         `OFS_RESULT_HI:     rd_data = result_q[15:8];
         `OFS_CROSSTALK:     rd_data = crosstalk_q;
         default:            rd_data = 8'h00; // RQ17
      endcase
   end

   // Serial target: address match, command decode, data writes and read shifting.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         port_state_q <= PS_IDLE;
         bit_q        <= 4'h0;
         shift_q      <= 8'h00;
         ack_phase_q  <= 1'b0;
         first_q      <= 1'b0;
         ptr_q        <= 5'h00;
         type_q       <= `TYPE_REPEAT;
         sda_oe       <= 1'b0;
         wr_stb       <= 1'b0;
         wr_addr      <= 5'h00;
         wr_data      <= 8'h00;
         clr_stb      <= 1'b0;
         force_stb    <= 1'b0;
      end else begin
         wr_stb    <= 1'b0;
         clr_stb   <= 1'b0;
         force_stb <= 1'b0;
         if (start_c) begin
            port_state_q <= PS_ADDR; // RQ7
            bit_q        <= 4'h0;
            ack_phase_q  <= 1'b0;
            sda_oe       <= 1'b0;
         end else if (stop_c) begin
            port_state_q <= PS_IDLE;
            ack_phase_q  <= 1'b0;
            sda_oe       <= 1'b0;
         end else if (scl_rise && port_state_q != PS_IDLE) begin
            if (ack_phase_q) begin
               if (port_state_q == PS_RD && sda_s2_q) begin
                  port_state_q <= PS_IDLE;
               end
            end else begin
               bit_q <= bit_q + 4'h1;
               if (port_state_q != PS_RD) begin
                  shift_q <= {shift_q[6:0], sda_s2_q};
               end
            end
         end else if (scl_fall && port_state_q != PS_IDLE) begin
            if (ack_phase_q) begin
               ack_phase_q <= 1'b0;
               bit_q       <= 4'h0;
               if (port_state_q == PS_RD) begin
                  shift_q <= rd_data; // RQ8
                  sda_oe  <= ~rd_data[7];
                  ptr_q   <= next_ptr(ptr_q, type_q); // RQ15
               end else begin
                  sda_oe <= 1'b0;
               end
            end else if (bit_q == 4'h8) begin
               case (port_state_q)
                  PS_ADDR: begin
                     if (shift_q[7:1] == BUS_ADDR) begin // RQ4
                        sda_oe       <= 1'b1;
                        ack_phase_q  <= 1'b1;
                        first_q      <= 1'b1;
                        port_state_q <= shift_q[0] ? PS_RD : PS_WR;
                     end else begin
                        port_state_q <= PS_IDLE;
                     end
                  end
                  PS_WR: begin
                     sda_oe      <= 1'b1;
                     ack_phase_q <= 1'b1;
                     first_q     <= 1'b0;
                     if (first_q && shift_q[`CMD_SELECT_BIT]) begin // RQ6
                        if (shift_q[`CMD_TYPE_HI:`CMD_TYPE_LO] == `TYPE_SPECIAL) begin // RQ10
                           clr_stb   <= (shift_q[4:0] == `SF_CLEAR_INT); // RQ11
                           force_stb <= (shift_q[4:0] == `SF_FORCE_INT); // RQ16
                        end else begin
                           ptr_q  <= shift_q[4:0]; // RQ10
                           type_q <= shift_q[`CMD_TYPE_HI:`CMD_TYPE_LO]; // RQ15
                        end
                     end else begin
                        wr_stb  <= 1'b1; // RQ9
                        wr_addr <= ptr_q;
                        wr_data <= shift_q;
                        ptr_q   <= next_ptr(ptr_q, type_q); // RQ15
                     end
                  end
                  default: begin
                     sda_oe      <= 1'b0;
                     ack_phase_q <= 1'b1;
                  end
               endcase
            end else if (port_state_q == PS_RD) begin
               shift_q <= {shift_q[6:0], 1'b0};
               sda_oe  <= ~shift_q[6];
            end
         end
      end
   end

   // Register writes; read-only and unused addresses are ignored.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_enable_q  <= `RST_ZERO;
         conv_time_q     <= `RST_CONV_TIME;
         wait_dur_q      <= `RST_WAIT_DUR;
         low_thr_lo_q    <= `RST_ZERO;
         low_thr_hi_q    <= `RST_ZERO;
         high_thr_lo_q   <= `RST_ZERO;
         high_thr_hi_q   <= `RST_ZERO;
         range_filter_q  <= `RST_ZERO;
         general_setup_q <= `RST_ZERO;
         pulse_count_q   <= `RST_ZERO;
         drive_gain_q    <= `RST_ZERO;
         crosstalk_q     <= `RST_ZERO;
      end else if (wr_stb) begin
         case (wr_addr)
            `OFS_STATE_ENABLE:  state_enable_q  <= wr_data;
            `OFS_CONV_TIME:     conv_time_q     <= wr_data;
            `OFS_WAIT_DUR:      wait_dur_q      <= wr_data;
            `OFS_LOW_THR_LO:    low_thr_lo_q    <= wr_data;
            `OFS_LOW_THR_HI:    low_thr_hi_q    <= wr_data;
            `OFS_HIGH_THR_LO:   high_thr_lo_q   <= wr_data;
            `OFS_HIGH_THR_HI:   high_thr_hi_q   <= wr_data;
            `OFS_RANGE_FILTER:  range_filter_q  <= wr_data;
            `OFS_GENERAL_SETUP: general_setup_q <= wr_data;
            `OFS_PULSE_COUNT:   pulse_count_q   <= wr_data;
            `OFS_DRIVE_GAIN:    drive_gain_q    <= wr_data;
            `OFS_CROSSTALK:     crosstalk_q     <= wr_data;
            default:            state_enable_q  <= state_enable_q; // RQ17
         endcase
      end
   end

   // Status flags and result capture; a setting event wins over a clear.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         result_q <= 16'h0000;
         valid_q  <= 1'b0;
         int_q    <= 1'b0;
         sat_q    <= 1'b0;
         prox_int <= 1'b0;
      end else begin
         if (cycle_done) begin
            result_q <= prox_result;
         end
         valid_q  <= run & (valid_q | cycle_done);
         int_q    <= prox_irq_event | force_stb | (int_q & ~clr_stb); // RQ16
         sat_q    <= prox_sat_event | (sat_q & ~clr_stb); // RQ16
         prox_int <= int_q & state_enable_q[`EN_INT_OUT_BIT];
      end
   end

   // Measurement cycle sequencer.
   prox_cycle_seq #(
      .UNIT_CYC        (UNIT_CYC)
   ) u_seq (
      .sys_clk         (sys_clk),
      .arst_n          (arst_n),
      .run             (run),
      .wait_en         (state_enable_q[`EN_WAIT_BIT]),
      .wait_stretch    (general_setup_q[`SETUP_STRETCH_BIT]),
      .led_pulse_count (pulse_count_q),
      .prox_conv_time  (conv_time_q),
      .wait_duration   (wait_dur_q),
      .led_on          (led_on),
      .seq_state       (seq_state),
      .cycle_done      (cycle_done)
   );
endmodule
`default_nettype wire

// *** tb/prox_host_port_sva.sv ***
// Purpose: Pin timing checks of the proximity host port.
// Assumes: UNIT_CYC equals the design's value.
// Notes:   Bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module prox_host_port_chk #(
   parameter int UNIT_CYC = 50
) (
   input wire logic       sys_clk,
   input wire logic       arst_n,
   input wire logic       scl_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic       led_on,
   input wire logic [2:0] seq_state
);
   logic [9:0] on_q;
   logic [9:0] off_q;
   logic [9:0] st_q;
   logic [2:0] prev_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // Counts LED on time, off time after a pulse, and dwell in a state.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         on_q <= 10'h0;
         off_q <= 10'h0;
         st_q <= 10'h0;
         prev_q <= 3'h0;
      end else begin
         on_q <= led_on ? on_q + 10'h1 : 10'h0;
         off_q <= (!led_on && seq_state == 3'h2 && ($fell(led_on) || off_q != 10'h0)) ? off_q + 10'h1 : 10'h0;
         st_q <= (seq_state == prev_q) ? st_q + 10'h1 : 10'h1;
         prev_q <= seq_state;
      end
   end
   // A pulse ends, or the next one starts, inside accumulation.
   sequence pulse_end;
      $fell(led_on) && seq_state == 3'h2;
   endsequence
   sequence pulse_next;
      $rose(led_on) && off_q != 10'h0;
   endsequence
   led_width_a: assert property (pulse_end |-> on_q == 10'h16d)
      else $error("LED on time wrong");
   led_gap_a: assert property (pulse_next |-> off_q == 10'h1b3)
      else $error("LED off time wrong");
   led_in_accum_a: assert property (led_on |-> seq_state == 3'h2)
      else $error("LED on outside accumulation");
   legal_state_a: assert property (seq_state <= 3'h5)
      else $error("Bad state code");
   state_order_a: assert property (seq_state != prev_q && seq_state != 3'h0 |->
      seq_state == prev_q + 3'h1 || (seq_state == 3'h1 && prev_q >= 3'h4)) else $error("State order wrong");
   fixed_state_a: assert property ((prev_q == 3'h1 && seq_state == 3'h2) || (prev_q == 3'h3 && seq_state == 3'h4) |->
      st_q == UNIT_CYC) else $error("Init or settle time wrong");
   oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
      else $error("SDA moved while clock high");
   sda_low_a: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("SDA drive not low");
endmodule
bind prox_host_port prox_host_port_chk #(.UNIT_CYC(UNIT_CYC)) u_chk (
   .sys_clk   (sys_clk),
   .arst_n    (arst_n),
   .scl_in    (scl_in),
   .sda_out   (sda_out),
   .sda_oe    (sda_oe),
   .led_on    (led_on),
   .seq_state (seq_state)
);
`default_nettype wire

// *** tb/host_bus_master.sv ***
// Purpose: Two-wire bus master in the host's place.
// Assumes: SDA has a pull-up; sda_m low pulls the wire.
// Notes:   Moves on falling sys_clk edges; q sets the rate.
`timescale 1ns/1ps
`default_nettype none
module host_bus_master (
   input  wire logic sys_clk,
   input  wire logic sda,
   output var logic  scl,
   output var logic  sda_m
);
   int q = 32;  // Quarter bit in clocks: 32 fast mode, 125 standard.
   // Bus idles released.
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // Waits n falling edges.
   task automatic tk(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // Start or repeated start: data falls while the clock is high.
   task automatic start();
      sda_m = 1'b1;
      tk(q);
      scl = 1'b1;
      tk(q);
      sda_m = 1'b0;
      tk(q);
      scl = 1'b0;
      tk(q);
   endtask
   // Stop: data rises while the clock is high.
   task automatic stop();
      sda_m = 1'b0;
      tk(q);
      scl = 1'b1;
      tk(q);
      sda_m = 1'b1;
      tk(2 * q);
   endtask
   // Nine bits MSB first; bit 0 is the acknowledge slot.
   task automatic xfer(input logic [8:0] d, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         sda_m = d[i];
         tk(q);
         scl = 1'b1;
         tk(2 * q);
         r[i] = sda;
         scl = 1'b0;
         tk(q);
      end
   endtask
endmodule
`default_nettype wire

// *** tb/prox_sensor_host_port_and_cycle_tb_top.sv ***
// Purpose: Self-checking bench of the proximity host port.
// Assumes: UNIT_CYC shortened to 50 clocks.
// Notes:   Register sweep from a table, then hand-written cases.
`timescale 1ns/1ps
`default_nettype none
module prox_sensor_host_port_and_cycle_tb_top;
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [15:0] prox_result = 16'hbeef;
   logic        irq_ev = 1'b0;
   logic        sat_ev = 1'b0;
   wire         sda_out;
   wire         sda_oe;
   wire         led_on;
   wire  [2:0]  seq_state;
   wire         prox_int;
   wire         scl;
   wire         sda_m;
   wire         sda = sda_m & ~(sda_oe & ~sda_out);
   int          fails = 0;
   int          check_count = 0;
   int          n;
   int          on_cnt = 0;
   logic [8:0]  r;
   logic [7:0]  v;
   logic [7:0]  exp_tab [32];
   prox_host_port #(
      .SIGNATURE (8'h3c),  // Arbitrary value.
      .UNIT_CYC  (50)
   ) DUT (
      .sys_clk        (sys_clk),
      .arst_n         (arst_n),
      .scl_in         (scl),
      .sda_in         (sda),
      .sda_out        (sda_out),
      .sda_oe         (sda_oe),
      .prox_result    (prox_result),
      .prox_irq_event (irq_ev),
      .prox_sat_event (sat_ev),
      .led_on         (led_on),
      .seq_state      (seq_state),
      .prox_int       (prox_int)
   );
   host_bus_master hm (
      .sys_clk (sys_clk),
      .sda     (sda),
      .scl     (scl),
      .sda_m   (sda_m)
   );
   // Clock and a watchdog well past the expected run.
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      #2800000;
      fails++;
      tally_and_finish();
   end
   // Counts clocks with the LED on.
   always @(negedge sys_clk) begin
      if (led_on === 1'b1)
         on_cnt++;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
      check_count++;
      if (seen !== expv) begin
         fails++;
         $display("FAIL %0t seen %h expected %h", $time, seen, expv);
      end
   endtask
   // Waits while seq_state equals s (eq set) or differs from it; n counts clocks.
   task automatic hold(input logic [2:0] s, input bit eq);
      n = 0;
      while ((seq_state === s) == eq && n < 8000) begin
         @(negedge sys_clk);
         n++;
      end
   endtask
   // Sends a byte that must be acknowledged.
   task automatic put(input logic [7:0] b);
      hm.xfer({b, 1'b1}, r);
      chk(r[0], 1'b0);
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d, input bit two);
      hm.start();
      put(8'h54);
      put(c);
      if (two)
         put(d);
      hm.stop();
   endtask
   // One byte read, after a command byte when cmd is set.
   task automatic rd(input logic [7:0] c, input bit cmd, output logic [7:0] b);
      hm.start();
      if (cmd) begin
         put(8'h54);
         put(c);
         hm.start();
      end
      put(8'h55);
      hm.xfer(9'h1ff, r);
      b = r[8:1];
      hm.stop();
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      exp_tab = '{default: 8'h00};
      exp_tab[2] = 8'hff;
      exp_tab[3] = 8'hff;
      exp_tab[18] = 8'h3c;
      repeat (6) @(negedge sys_clk);
      arst_n = 1'b1;
      hm.tk(4);
      // Every address read back by one auto-increment combined read.
      hm.start();
      put(8'h54);
      put(8'ha0);
      hm.start();
      put(8'h55);
      for (int a = 0; a < 32; a++) begin
         hm.xfer({8'hff, a == 31}, r);
         chk(r[8:1], exp_tab[a]);
      end
      hm.stop();
      // Standard rate write, then a foreign address at fast rate.
      hm.q = 125;
      wr(8'h8e, 8'h07, 1'b1);
      hm.q = 32;
      hm.start();
      hm.xfer({8'h56, 1'b1}, r);
      chk(r[0], 1'b1);
      hm.stop();
      // Data without command lands at the kept pointer.
      wr(8'h02, 8'h00, 1'b0);
      rd(8'h00, 1'b0, v);
      chk(v, 8'h02);
      wr(8'h92, 8'h00, 1'b1);
      rd(8'h00, 1'b0, v);
      chk(v, 8'h3c);
      // Two pulses per cycle, then a stretched wait.
      wr(8'h8d, 8'h02, 1'b1);
      wr(8'h80, 8'h2d, 1'b1);
      hold(3'h5, 1'b0);
      chk(on_cnt[15:0], 16'h2da);
      hold(3'h5, 1'b1);
      chk(n[15:0], 16'h258);
      hm.start();
      put(8'h54);
      put(8'hb8);
      hm.start();
      put(8'h55);
      hm.xfer(9'h1fe, r);
      chk(r[8:1], 8'hef);
      hm.xfer(9'h1ff, r);
      chk(r[8:1], 8'hbe);
      hm.stop();
      // Interrupt raised, cleared, forced; saturation cleared.
      irq_ev = 1'b1;
      @(negedge sys_clk);
      irq_ev = 1'b0;
      hm.tk(3);
      chk(prox_int, 1'b1);
      wr(8'he5, 8'h00, 1'b0);
      chk(prox_int, 1'b0);
      wr(8'he4, 8'h00, 1'b0);
      sat_ev = 1'b1;
      @(negedge sys_clk);
      sat_ev = 1'b0;
      chk(prox_int, 1'b1);
      rd(8'h93, 1'b1, v);
      chk(v[6:5], 2'h3);
      wr(8'he5, 8'h00, 1'b0);
      rd(8'h00, 1'b0, v);
      chk(v[6:5], 2'h0);
      // Auto-increment write over 0x00..0x02: wait off, two conversion units.
      hm.start();
      put(8'h54);
      put(8'ha0);
      put(8'h05);
      put(8'h00);
      put(8'hfe);
      hm.stop();
      hold(3'h3, 1'b0);
      hold(3'h4, 1'b0);
      hold(3'h4, 1'b1);
      chk(n[15:0], 16'h0064);
      chk(seq_state, 3'h1);
      // Reset in mid-run: outputs idle, pointer and enable back to defaults.
      arst_n = 1'b0;
      @(negedge sys_clk);
      chk({led_on, seq_state, prox_int, sda_oe}, 6'h00);
      arst_n = 1'b1;
      rd(8'h00, 1'b0, v);
      chk(v, 8'h00);
      tally_and_finish();
   end
endmodule
`default_nettype wire
